/* File: rtl/ocfr_pkg.sv */
// Constants, types and state encodings for the overcurrent fault responder.
// Assumes a 10 MHz core clock and a management link that delivers register writes.
// What this block does
// (R1) Code 01: limit current, shut down on low voltage.
// (R2) Code 10: limit for delay, then apply retry.
// (R3) Code 11: shut down at once, then retry.
// (R4) Retry 000: never restart, stay off.
// (R5) Retry 1..6: try that often, then latch off.
// (R6) Retry all ones: retry without limit.
// (R7) Restart spacing equals delay units times unit.
// (R8) Every fault sets status bit and notifies host.
// (R9) Delay field decodes as two to the power.
// (R10) Code 00: limit current forever, ignore voltage.
// (R11) Attempt counter clears per episode or clear.
package ocfr_pkg;
  localparam int          CFG_W          = 8;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam int          RESP_HI        = 7;
  localparam int          RESP_LO        = 6;
  localparam int          RETRY_HI       = 5;
  localparam int          RETRY_LO       = 3;
  localparam int          DELAY_HI       = 2;
  localparam int          DELAY_LO       = 0;
  localparam logic [1:0]  RESP_IGNORE    = 2'h0;
  localparam logic [1:0]  RESP_COND_CC   = 2'h1;
  localparam logic [1:0]  RESP_DELAY_CC  = 2'h2;
  localparam logic [1:0]  RESP_DISABLE   = 2'h3;
  localparam logic [2:0]  RETRY_NONE     = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER  = 3'h7;
  localparam int          UNIT_W         = 16;
  localparam int          DCNT_W         = 24;
  localparam logic [23:0] DCNT_ONE       = 24'h000001;
  localparam logic [2:0]  ATT_ZERO       = 3'h0;

  typedef enum logic [2:0] {
    OCFR_RUN     = 3'b000,
    OCFR_LIMIT   = 3'b001,
    OCFR_OFF_WT  = 3'b010,
    OCFR_RESTART = 3'b011,
    OCFR_LATCHED = 3'b100
  } ocfr_state_t;

  typedef struct packed {
    logic oc_fault;
    logic low_voltage;
    logic fault_clear;
  } ocfr_sense_t;

  typedef struct packed {
    logic output_enable;
    logic current_limit;
    logic status_oc_fault;
    logic notify;
    logic latched_off;
  } ocfr_ctrl_t;
endpackage

/* File: rtl/ocfr_responder.sv */
// Overcurrent fault response controller: config register, response state machine, retries.
// Assumes fault, low-voltage and clear inputs are pins from outside this clock domain.
`timescale 1ns/1ps
module ocfr_responder
  import ocfr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              cfg_wr,
  input  wire logic [CFG_W-1:0]  cfg_wdata,
  output logic [CFG_W-1:0]       cfg_rdata,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  input  wire ocfr_sense_t       sense_in,
  output ocfr_ctrl_t             ctrl_out,
  output logic [2:0]             attempts_used
);
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  ocfr_sense_t      s1_r;
  ocfr_sense_t      s2_r;
  ocfr_sense_t      s3_r;
  ocfr_sense_t      sv_r;
  ocfr_sense_t      sv_nxt;
  ocfr_state_t      st_r;
  ocfr_state_t      st_nxt;
  logic [2:0]       att_r;
  logic [2:0]       att_nxt;
  ocfr_ctrl_t       ctl_r;
  ocfr_ctrl_t       ctl_nxt;
  logic             tmr_start;
  logic             tmr_done;
  logic [1:0]       resp;
  logic [2:0]       retry;
  logic             fault_rise;

  assign resp  = cfg_r[RESP_HI:RESP_LO];
  assign retry = cfg_r[RETRY_HI:RETRY_LO];

  // Pin inputs take three stages; a change is accepted once stages two and three agree.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= sense_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_comb begin
    sv_nxt = sv_r;
    if (s2_r.oc_fault == s3_r.oc_fault) sv_nxt.oc_fault = s3_r.oc_fault;
    if (s2_r.low_voltage == s3_r.low_voltage) sv_nxt.low_voltage = s3_r.low_voltage;
    if (s2_r.fault_clear == s3_r.fault_clear) sv_nxt.fault_clear = s3_r.fault_clear;
  end

  assign fault_rise = sv_nxt.oc_fault && !sv_r.oc_fault;

  always_comb begin
    cfg_nxt = cfg_wr ? cfg_wdata : cfg_r;
  end

  // Retries remain while the count is below the programmed value or retry is unlimited.
  function automatic logic may_retry(input logic [2:0] rc, input logic [2:0] used);
    may_retry = (rc == RETRY_FOREVER) || (used < rc); // (R5) (R6)
  endfunction

  always_comb begin
    st_nxt    = st_r;
    att_nxt   = att_r;
    ctl_nxt   = ctl_r;
    tmr_start = 1'b0;
    ctl_nxt.notify = 1'b0;
    if (sv_r.oc_fault) ctl_nxt.status_oc_fault = 1'b1; // (R8)
    if (fault_rise) ctl_nxt.notify = 1'b1; // (R8)
    if (sv_r.fault_clear) ctl_nxt.status_oc_fault = sv_r.oc_fault;
    case (st_r)
      OCFR_RUN: begin
        ctl_nxt.output_enable = 1'b1;
        ctl_nxt.current_limit = 1'b0;
        // A restart that recovered leaves its count behind; the next episode starts from zero.
        if (fault_rise || sv_r.fault_clear) att_nxt = ATT_ZERO; // (R11)
        if (sv_r.oc_fault) begin
          case (resp)
            RESP_IGNORE: begin
              st_nxt = OCFR_LIMIT; // (R10)
            end
            RESP_COND_CC: begin
              st_nxt = OCFR_LIMIT; // (R1)
            end
            RESP_DELAY_CC: begin
              st_nxt    = OCFR_LIMIT; // (R2)
              tmr_start = 1'b1;
            end
            default: begin
              st_nxt = OCFR_OFF_WT; // (R3)
              ctl_nxt.output_enable = 1'b0;
              tmr_start = 1'b1;
            end
          endcase
        end
      end
      OCFR_LIMIT: begin
        ctl_nxt.current_limit = 1'b1;
        if (!sv_r.oc_fault) begin
          st_nxt = OCFR_RUN;
        end else if ((resp == RESP_COND_CC && sv_r.low_voltage) ||
                     (resp == RESP_DELAY_CC && tmr_done) || resp == RESP_DISABLE) begin
          st_nxt = OCFR_OFF_WT; // (R1) (R2)
          ctl_nxt.output_enable = 1'b0;
          ctl_nxt.current_limit = 1'b0;
          tmr_start = 1'b1;
        end
      end
      OCFR_OFF_WT: begin
        ctl_nxt.output_enable = 1'b0;
        if (!may_retry(retry, att_r)) begin
          st_nxt = OCFR_LATCHED; // (R4) (R5)
        end else if (tmr_done) begin
          st_nxt = OCFR_RESTART; // (R7)
          ctl_nxt.output_enable = 1'b1;
          tmr_start = 1'b1;
          if (retry != RETRY_FOREVER) att_nxt = att_r + 3'h1;
        end
      end
      OCFR_RESTART: begin
        // The restart succeeds if the fault has gone by the next attempt slot.
        if (!sv_r.oc_fault) begin
          st_nxt = OCFR_RUN;
        end else if (tmr_done) begin
          if (may_retry(retry, att_r)) begin
            ctl_nxt.output_enable = 1'b1;
            tmr_start = 1'b1; // (R7)
            if (retry != RETRY_FOREVER) att_nxt = att_r + 3'h1;
          end else begin
            st_nxt = OCFR_LATCHED; // (R5)
            ctl_nxt.output_enable = 1'b0;
          end
        end else begin
          ctl_nxt.output_enable = 1'b1;
        end
      end
      OCFR_LATCHED: begin
        ctl_nxt.output_enable = 1'b0;
        ctl_nxt.current_limit = 1'b0;
        if (sv_r.fault_clear) begin
          st_nxt  = OCFR_RUN;
          att_nxt = ATT_ZERO; // (R11)
        end
      end
      default: begin
        st_nxt = OCFR_RUN;
      end
    endcase
    ctl_nxt.latched_off = (st_nxt == OCFR_LATCHED);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
      sv_r  <= '0;
      st_r  <= OCFR_RUN;
      att_r <= ATT_ZERO;
      ctl_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      sv_r  <= sv_nxt;
      st_r  <= st_nxt;
      att_r <= att_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  ocfr_timer u_timer (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .start       (tmr_start),
    .delay_code  (cfg_r[DELAY_HI:DELAY_LO]),
    .unit_cycles (unit_cycles),
    .expired     (tmr_done)
  );

  assign cfg_rdata     = cfg_r;
  assign ctrl_out      = ctl_r;
  assign attempts_used = att_r;
endmodule

/* File: rtl/ocfr_timer.sv */
// Delay timer: loads a count of time units and pulses when it runs out.
// Assumes the unit length in core clock cycles is supplied by the caller.
`timescale 1ns/1ps
module ocfr_timer
  import ocfr_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              start,
  input  wire logic [2:0]        delay_code,
  input  wire logic [UNIT_W-1:0] unit_cycles,
  output logic                   expired
);
  logic [DCNT_W-1:0] cnt_r;
  logic [DCNT_W-1:0] cnt_nxt;
  logic              run_r;
  logic              run_nxt;

  // Power-of-two decode of the delay field.
  function automatic logic [DCNT_W-1:0] units_of(input logic [2:0] code);
    units_of = DCNT_ONE << code; // (R9)
  endfunction

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start) begin
      // A zero unit length still gives at least one cycle per unit.
      cnt_nxt = DCNT_W'(units_of(delay_code) * DCNT_W'((unit_cycles == '0) ? 16'h0001 : unit_cycles));
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= DCNT_ONE) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - DCNT_ONE;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  // Expiry is decoded from the count so the caller acts exactly one delay after the load.
  assign expired = run_r && (cnt_r <= DCNT_ONE);
endmodule

/* File: tb/ocfr_host_model.sv */
// Host model on the management side: writes the response config.
// Assumes core_clk is the responder clock; drives just after falling edges.
`timescale 1ns/1ps
module ocfr_host_model
  import ocfr_pkg::*;
(
  input  wire logic       core_clk,
  output logic            cfg_wr,
  output logic [CFG_W-1:0] cfg_wdata
);
  initial begin
    cfg_wr    = 1'b0;
    cfg_wdata = 8'h5a;
  end
  // Released data shows the inverse so a stale value is never taken as valid.
  task automatic wr(input logic [7:0] v);
    @(negedge core_clk);
    cfg_wr    <= 1'b1;
    cfg_wdata <= v;
    @(negedge core_clk);
    cfg_wr    <= 1'b0;
    cfg_wdata <= ~v;
  endtask
endmodule

/* File: tb/ocfr_responder_chk.sv */
// Port checker for the fault responder.
// Assumes config is rewritten only after a clear with no fault.
`timescale 1ns/1ps
module ocfr_responder_chk
  import ocfr_pkg::*;
(
  input wire logic [0:0]  core_clk,
  input wire logic [0:0]  rstn,
  input wire logic [7:0]  cfg_rdata,
  input wire ocfr_sense_t sense_in,
  input wire ocfr_ctrl_t  ctrl_out,
  input wire logic [2:0]  attempts_used
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  notify_on_fault_a: assert property ($rose(sense_in.oc_fault) |-> ##[1:8] ctrl_out.notify)
    else $error("no notify");
  status_set_a: assert property (ctrl_out.notify |-> ##[0:1] ctrl_out.status_oc_fault)
    else $error("no status");
  latch_dark_a: assert property (ctrl_out.latched_off |-> !ctrl_out.output_enable)
    else $error("latched but on");
  retry_cap_a: assert property (cfg_rdata[5:3] != 3'h7 |-> attempts_used <= cfg_rdata[5:3])
    else $error("too many tries");
  attempt_step_a: assert property (attempts_used != $past(attempts_used) |->
    attempts_used == $past(attempts_used) + 3'h1 || attempts_used == 3'h0)
    else $error("attempt jump");
  ignore_runs_a: assert property (cfg_rdata[7:6] == RESP_IGNORE && ctrl_out.current_limit
    |-> ctrl_out.output_enable) else $error("ignore shut");
  disable_fast_a: assert property (cfg_rdata[7:6] == RESP_DISABLE &&
    $rose(sense_in.oc_fault) |-> ##[1:8] !ctrl_out.output_enable) else $error("no shut");
  clear_episode_a: assert property ((sense_in.fault_clear && !sense_in.oc_fault) [*8]
    |-> !ctrl_out.latched_off && attempts_used == 3'h0) else $error("clear lost");
endmodule
bind ocfr_responder ocfr_responder_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .cfg_rdata(cfg_rdata), .sense_in(sense_in), .ctrl_out(ctrl_out),
  .attempts_used(attempts_used));

/* File: tb/ocfr_responder_tb_top.sv */
// Self-checking bench for the fault responder.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
module ocfr_responder_tb_top;
  import ocfr_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cfg_wr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic [15:0] unit_cycles = 16'h0004;
  ocfr_sense_t sense_in = '0;
  ocfr_ctrl_t  ctrl_out;
  logic [2:0]  attempts_used;
  int          n_errors, num_checks, cyc, k;
  always #50 core_clk = ~core_clk;
  ocfr_host_model u_host (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));
  ocfr_responder u_dut (.core_clk(core_clk), .rstn(rstn), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .unit_cycles(unit_cycles),
    .sense_in(sense_in), .ctrl_out(ctrl_out), .attempts_used(attempts_used));
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude;
    end
  end
  // Clear the last episode, then arm a new config and raise the fault.
  task automatic ep(input logic [7:0] c);
    sense_in = 3'b001;
    wt(10);
    sense_in = '0;
    u_host.wr(c);
    wt(2);
    chk(cfg_rdata, c);
    sense_in.oc_fault = 1'b1;
  endtask
  task automatic t_retry;
    for (int r = 0; r < 6; r++) begin
      ep({2'h3, r[2:0], 3'h1});
      wt(100);
      chk({ctrl_out.latched_off, ctrl_out.output_enable, ctrl_out.status_oc_fault, 2'h0,
        attempts_used}, {3'b101, 2'h0, r[2:0]});
    end
    $display("retry test done");
  endtask
  task automatic t_space;
    for (int d = 1; d < 4; d++) begin
      ep({5'b11010, d[2:0]});
      for (k = 0; k < 100 && attempts_used !== 3'h1; k++) wt(1);
      k = 0;
      do begin wt(1); k++; end while (k < 90 && attempts_used !== 3'h2);
      chk(k[7:0], 8'h04 << d);
    end
    $display("spacing test done");
  endtask
  task automatic t_delay;
    ep(8'h82);
    wt(12);
    chk({6'h0, ctrl_out.current_limit, ctrl_out.output_enable}, 8'h03);
    wt(25);
    chk({6'h0, ctrl_out.latched_off, ctrl_out.output_enable}, 8'h02);
    $display("delay test done");
  endtask
  task automatic t_lv;
    for (int c = 0; c < 2; c++) begin
      ep({c[1:0], 6'h0});
      wt(10);
      chk({6'h0, ctrl_out.current_limit, ctrl_out.output_enable}, 8'h03);
      sense_in.low_voltage = 1'b1;
      wt(15);
      chk({7'h0, ctrl_out.output_enable}, {7'h0, c == 0});
    end
    $display("voltage test done");
  endtask
  task automatic t_forever;
    ep(8'hf9);
    wt(200);
    chk({7'h0, ctrl_out.latched_off}, 8'h00);
    $display("forever test done");
  endtask
  initial begin
    wt(5);
    rstn = 1'b1;
    wt(3);
    chk(cfg_rdata, 8'h00);
    chk({7'h0, ctrl_out.output_enable}, 8'h01);
    t_retry;
    t_space;
    t_delay;
    t_lv;
    t_forever;
    conclude;
  end
endmodule
